// >>> core/eefl_cfg.svh
// constants of the ethernet event flag logic
// Notes on behaviour
// - abort on retries, window, late collision
// - abort when deferral limit reached, no wait
// - abort oversize frame unless huge allowed
// - abort sets sticky tx error flag
// - tx error with enables drives request low
// - abort clears request, sets aborted, writes vector
// - tx error sets tx done same cycle
// - full duplex: only oversize causes error
// - request falling edge sets tx done
// - link flag stays clear by default
// - link flag mirrors phy global flag
// - link request needs all four enables
// - phy flag read clears link flags
// - copy start falling edge sets done
// - rx pending set while counter nonzero
// - rx pending clears when counter zero
// - new packet with enables drives request
// - copy done requests only when enabled
// - wake packet raises counter and request
// - global enable low keeps request high
`ifndef EEFL_CFG_SVH
`define EEFL_CFG_SVH
`define EEFL_A_FLAGS    3'h0
`define EEFL_A_ENABLES  3'h1
`define EEFL_A_CTRL     3'h2
`define EEFL_A_STATUS   3'h3
`define EEFL_A_PHYFLAG  3'h4
`define EEFL_A_PHYEN    3'h5
`define EEFL_A_PKTCNT   3'h6
`define EEFL_A_CFG      3'h7
`define EEFL_B_RXPEND   6
`define EEFL_B_COPY     5
`define EEFL_B_LINK     4
`define EEFL_B_TXDONE   3
`define EEFL_B_TXERR    1
`define EEFL_B_GLOBAL   7
`define EEFL_B_COPYST   5
`define EEFL_B_TXREQ    3
`define EEFL_B_LATE_COLLISION_SEEN  4
`define EEFL_B_ABORTED  1
`define EEFL_B_PLNK     4
`define EEFL_B_PGLB     2
`define EEFL_B_DUPLEX   0
`define EEFL_B_WAITF    1
`define EEFL_B_HUGE     2
`define EEFL_LATE_BYTES 16'h0040
`define EEFL_WAIT_FOREVER_CFG_NS   2428700
`define EEFL_CLK_NS     4
`define EEFL_WAIT_FOREVER_CFG_CYC  (`EEFL_WAIT_FOREVER_CFG_NS / `EEFL_CLK_NS)
`endif

// >>> core/eefl_pkg.sv
// types of the ethernet event flag logic
package eefl_pkg;
    typedef enum logic [1:0] {
        TX_IDLE  = 2'b00,
        TX_WAIT_FOREVER_CFG = 2'b01,
        TX_SEND  = 2'b10
    } eefl_tx_type;
endpackage : eefl_pkg

// >>> core/eefl_top.sv
// event flags, abort detection and active-low request output
`timescale 1ns/1ns
`default_nettype none
`include "eefl_cfg.svh"
module eefl_top #(
    parameter int WAIT_FOREVER_CFG_CYC = `EEFL_WAIT_FOREVER_CFG_CYC
) (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // register port
    input  wire logic [2:0]  addr_i,
    input  wire logic [7:0]  wdata_i,
    input  wire logic        wr_i,
    input  wire logic        clr_i,
    input  wire logic        rd_i,
    output logic      [7:0]  rdata_o,
    // mac and receive events
    input  wire logic        medium_busy_i,
    input  wire logic        tx_byte_i,
    input  wire logic        tx_end_i,
    input  wire logic        collision_i,
    input  wire logic [3:0]  retry_maximum_i,
    input  wire logic [15:0] collision_window_i,
    input  wire logic [15:0] max_frame_length_i,
    input  wire logic        per_packet_cfg_select_i,
    input  wire logic        per_packet_huge_allow_i,
    input  wire logic        phy_link_event_i,
    input  wire logic        copy_engine_finish_i,
    input  wire logic        rx_packet_stored_i,
    input  wire logic        power_save_i,
    input  wire logic        rx_enable_i,
    // outputs
    output logic             tx_vector_write_o,
    output logic             request_n_o
);
    // registered state
    logic [7:0]            enable_q;
    logic [7:0]            cfg_q;
    logic [1:0]            phy_en_q;
    logic                  tx_err_q;
    logic                  tx_done_q;
    logic                  copy_done_q;
    logic                  plnk_q;
    logic                  tx_request_q;
    logic                  copy_start_q;
    logic                  late_q;
    logic                  abort_st_q;
    logic [7:0]            pkt_cnt_q;
    logic [15:0]           byte_q;
    logic [3:0]            retry_q;
    logic [31:0]           wait_forever_cfg_q;
    eefl_pkg::eefl_tx_type st_q;
    // decoded events
    logic                  abort;
    logic                  req_fall;
    logic                  copy_fall;
    logic                  link_flag;
    logic                  rx_pend;
    logic                  pkt_dec;
    logic                  phy_rd;
    logic                  rx_new;
    logic                  full_duplex;
    logic                  huge_ok;
    logic                  late_hit;
    logic                  tx_fin;

    function automatic logic wr_at(input logic [2:0] a, input logic [2:0] r);
        wr_at = wr_i && (a == r);
    endfunction : wr_at

    //------------------------------------------------
    // abort detection
    //------------------------------------------------
    assign full_duplex = cfg_q[`EEFL_B_DUPLEX];
    assign huge_ok = cfg_q[`EEFL_B_HUGE] || (per_packet_cfg_select_i && per_packet_huge_allow_i);
    assign late_hit = byte_q >= `EEFL_LATE_BYTES;
    assign tx_fin = tx_request_q && st_q == eefl_pkg::TX_SEND && tx_end_i;
    always_comb begin
        abort = 1'b0;
        // state lags a host cancel by one cycle, so gate on the request itself
        if (tx_request_q && st_q == eefl_pkg::TX_SEND) begin
            if (tx_byte_i && !huge_ok && byte_q >= max_frame_length_i)
                abort = 1'b1;
            if (!full_duplex && collision_i && (retry_q >= retry_maximum_i ||
                byte_q > collision_window_i || late_hit))
                abort = 1'b1;
        end else if (tx_request_q && st_q == eefl_pkg::TX_WAIT_FOREVER_CFG) begin
            if (!full_duplex && !cfg_q[`EEFL_B_WAITF] && medium_busy_i &&
                wait_forever_cfg_q >= 32'(WAIT_FOREVER_CFG_CYC - 1))
                abort = 1'b1;
        end
    end

    // byte and deferral counters restart on every new attempt, retry_q counts up instead; all restart after every abort
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            st_q <= eefl_pkg::TX_IDLE;
            byte_q <= 16'h0000;
            retry_q <= 4'h0;
            wait_forever_cfg_q <= 32'h0000_0000;
        end else if (!tx_request_q || abort) begin
            st_q <= eefl_pkg::TX_IDLE;
            byte_q <= 16'h0000;
            retry_q <= 4'h0;
            wait_forever_cfg_q <= 32'h0000_0000;
        end else begin
            case (st_q)
                eefl_pkg::TX_IDLE: st_q <= eefl_pkg::TX_WAIT_FOREVER_CFG;
                eefl_pkg::TX_WAIT_FOREVER_CFG: begin
                    if (medium_busy_i && !full_duplex) begin
                        wait_forever_cfg_q <= wait_forever_cfg_q + 32'h1;
                    end else begin
                        st_q <= eefl_pkg::TX_SEND;
                    end
                end
                eefl_pkg::TX_SEND: begin
                    if (collision_i && !full_duplex) begin
                        retry_q <= retry_q + 4'h1;
                        byte_q <= 16'h0000;
                        wait_forever_cfg_q <= 32'h0000_0000;
                        st_q <= eefl_pkg::TX_WAIT_FOREVER_CFG;
                    end else if (tx_byte_i) begin
                        byte_q <= byte_q + 16'h1;
                    end
                end
                default: st_q <= eefl_pkg::TX_IDLE;
            endcase
        end
    end

    //------------------------------------------------
    // control and status bits
    //------------------------------------------------
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            tx_request_q <= 1'b0;
            copy_start_q <= 1'b0;
            late_q <= 1'b0;
            abort_st_q <= 1'b0;
            tx_vector_write_o <= 1'b0;
        end else begin
            tx_vector_write_o <= abort || tx_fin;
            if (abort || tx_fin)
                tx_request_q <= 1'b0;
            else if (wr_at(addr_i, `EEFL_A_CTRL))
                tx_request_q <= wdata_i[`EEFL_B_TXREQ];
            else if (clr_i && addr_i == `EEFL_A_CTRL && wdata_i[`EEFL_B_TXREQ])
                tx_request_q <= 1'b0;
            if (copy_engine_finish_i)
                copy_start_q <= 1'b0;
            else if (wr_at(addr_i, `EEFL_A_CTRL))
                copy_start_q <= wdata_i[`EEFL_B_COPYST];
            else if (clr_i && addr_i == `EEFL_A_CTRL && wdata_i[`EEFL_B_COPYST])
                copy_start_q <= 1'b0;
            if (abort)
                abort_st_q <= 1'b1;
            else if (clr_i && addr_i == `EEFL_A_STATUS && wdata_i[`EEFL_B_ABORTED])
                abort_st_q <= 1'b0;
            if (abort && collision_i && late_hit)
                late_q <= 1'b1;
            else if (clr_i && addr_i == `EEFL_A_STATUS && wdata_i[`EEFL_B_LATE_COLLISION_SEEN])
                late_q <= 1'b0;
        end
    end

    //------------------------------------------------
    // event flags
    //------------------------------------------------
    assign req_fall = tx_request_q && (abort || (st_q == eefl_pkg::TX_SEND && tx_end_i) ||
        (wr_at(addr_i, `EEFL_A_CTRL) && !wdata_i[`EEFL_B_TXREQ]) ||
        (clr_i && addr_i == `EEFL_A_CTRL && wdata_i[`EEFL_B_TXREQ]));
    assign copy_fall = copy_start_q && (copy_engine_finish_i ||
        (wr_at(addr_i, `EEFL_A_CTRL) && !wdata_i[`EEFL_B_COPYST]) ||
        (clr_i && addr_i == `EEFL_A_CTRL && wdata_i[`EEFL_B_COPYST]));
    assign phy_rd = rd_i && addr_i == `EEFL_A_PHYFLAG;
    assign pkt_dec = clr_i && addr_i == `EEFL_A_PKTCNT && pkt_cnt_q != 8'h00;
    assign rx_new = rx_packet_stored_i && !power_save_i && rx_enable_i && pkt_cnt_q != 8'hFF;
    assign link_flag = plnk_q && phy_en_q[0] && phy_en_q[1];
    assign rx_pend = pkt_cnt_q != 8'h00;

    function automatic logic bit_clr(input int b);
        bit_clr = clr_i && addr_i == `EEFL_A_FLAGS && wdata_i[b];
    endfunction : bit_clr

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            tx_err_q <= 1'b0;
            tx_done_q <= 1'b0;
            copy_done_q <= 1'b0;
        end else begin
            if (abort)
                tx_err_q <= 1'b1;
            else if (bit_clr(`EEFL_B_TXERR))
                tx_err_q <= 1'b0;
            if (req_fall)
                tx_done_q <= 1'b1;
            else if (bit_clr(`EEFL_B_TXDONE))
                tx_done_q <= 1'b0;
            if (copy_fall)
                copy_done_q <= 1'b1;
            else if (bit_clr(`EEFL_B_COPY))
                copy_done_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            plnk_q <= 1'b0;
            phy_en_q <= 2'b00;
        end else begin
            if (phy_link_event_i)
                plnk_q <= 1'b1;
            else if (phy_rd)
                plnk_q <= 1'b0;
            if (wr_at(addr_i, `EEFL_A_PHYEN))
                phy_en_q <= {wdata_i[`EEFL_B_PLNK], wdata_i[`EEFL_B_PGLB - 1]};
        end
    end

    // a store and a decrement in one cycle cancel out
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i)
            pkt_cnt_q <= 8'h00;
        else if (rx_new && !pkt_dec)
            pkt_cnt_q <= pkt_cnt_q + 8'h01;
        else if (pkt_dec && !rx_new)
            pkt_cnt_q <= pkt_cnt_q - 8'h01;
    end

    //------------------------------------------------
    // enables and configuration
    //------------------------------------------------
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            enable_q <= 8'h00;
            cfg_q <= 8'h00;
        end else begin
            if (wr_at(addr_i, `EEFL_A_ENABLES))
                enable_q <= wdata_i & 8'hFA;
            if (wr_at(addr_i, `EEFL_A_CFG))
                cfg_q <= wdata_i & 8'h07;
        end
    end

    //------------------------------------------------
    // request output and read data
    //------------------------------------------------
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i)
            request_n_o <= 1'b1;
        else
            request_n_o <= !(enable_q[`EEFL_B_GLOBAL] && (
                (tx_err_q && enable_q[`EEFL_B_TXERR]) ||
                (tx_done_q && enable_q[`EEFL_B_TXDONE]) ||
                (link_flag && enable_q[`EEFL_B_LINK]) ||
                (copy_done_q && enable_q[`EEFL_B_COPY]) ||
                (rx_pend && enable_q[`EEFL_B_RXPEND])));
    end

    // read data stand one cycle after the strobe, zero otherwise
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i)
            rdata_o <= 8'h00;
        else if (rd_i) begin
            case (addr_i)
                `EEFL_A_FLAGS: rdata_o <= {1'b0, rx_pend, copy_done_q, link_flag,
                                           tx_done_q, 1'b0, tx_err_q, 1'b0};
                `EEFL_A_ENABLES: rdata_o <= enable_q;
                `EEFL_A_CTRL: rdata_o <= {2'b00, copy_start_q, 1'b0, tx_request_q, 3'b000};
                `EEFL_A_STATUS: rdata_o <= {!request_n_o, 2'b00, late_q, 2'b00, abort_st_q, 1'b0};
                `EEFL_A_PHYFLAG: rdata_o <= {3'b000, link_flag, 1'b0, link_flag, 2'b00};
                `EEFL_A_PHYEN: rdata_o <= {3'b000, phy_en_q[1], 2'b00, phy_en_q[0], 1'b0};
                `EEFL_A_PKTCNT: rdata_o <= pkt_cnt_q;
                `EEFL_A_CFG: rdata_o <= cfg_q;
                default: rdata_o <= 8'h00;
            endcase
        end else
            rdata_o <= 8'h00;
    end

    //------------------------------------------------
    // checks
    //------------------------------------------------
    a_err_sets_done: assert property (@(posedge clk_i) disable iff (rst_i)
        abort |=> tx_err_q && tx_done_q) else $error("abort missed flags");
    a_err_sticky: assert property (@(posedge clk_i) disable iff (rst_i)
        tx_err_q && !bit_clr(`EEFL_B_TXERR) |=> tx_err_q) else $error("error flag lost");
    a_abort_drops_req: assert property (@(posedge clk_i) disable iff (rst_i)
        abort |=> !tx_request_q && abort_st_q && tx_vector_write_o) else $error("abort");
    a_global_off_high: assert property (@(posedge clk_i) disable iff (rst_i)
        !enable_q[`EEFL_B_GLOBAL] |=> request_n_o) else $error("request while off");
    a_err_request: assert property (@(posedge clk_i) disable iff (rst_i)
        tx_err_q && enable_q[`EEFL_B_TXERR] && enable_q[`EEFL_B_GLOBAL] |=> !request_n_o)
        else $error("error request missing");
    a_rx_pending: assert property (@(posedge clk_i) disable iff (rst_i)
        rx_new && !pkt_dec |=> rx_pend) else $error("pending not set");
    a_link_default: assert property (@(posedge clk_i) disable iff (rst_i)
        phy_en_q != 2'b11 |-> !link_flag) else $error("link flag while disabled");
    a_phy_read_clear: assert property (@(posedge clk_i) disable iff (rst_i)
        phy_rd && !phy_link_event_i |=> !link_flag) else $error("read did not clear");
    a_copy_done: assert property (@(posedge clk_i) disable iff (rst_i)
        $fell(copy_start_q) |-> copy_done_q) else $error("copy done missing");
    a_duplex_only_size: assert property (@(posedge clk_i) disable iff (rst_i)
        full_duplex && abort |-> st_q == eefl_pkg::TX_SEND && !huge_ok)
        else $error("duplex abort cause");

    //------------------------------------------------
    // checks on transmit abort
    //------------------------------------------------
    a_retry_abort: assert property (@(posedge clk_i) disable iff (rst_i)
        tx_request_q && st_q == eefl_pkg::TX_SEND && !full_duplex && collision_i &&
        retry_q >= retry_maximum_i |-> abort)
        else $error("retry abort missing");
    a_late_status: assert property (@(posedge clk_i) disable iff (rst_i)
        abort && collision_i && late_hit |=> late_q)
        else $error("late collision not marked");
    a_wait_forever_cfg_abort: assert property (@(posedge clk_i) disable iff (rst_i)
        tx_request_q && st_q == eefl_pkg::TX_WAIT_FOREVER_CFG && !full_duplex && !cfg_q[`EEFL_B_WAITF] &&
        medium_busy_i && wait_forever_cfg_q >= 32'(WAIT_FOREVER_CFG_CYC - 1) |-> abort)
        else $error("deferral abort missing");
    a_size_abort: assert property (@(posedge clk_i) disable iff (rst_i)
        tx_request_q && st_q == eefl_pkg::TX_SEND && tx_byte_i && !huge_ok &&
        byte_q >= max_frame_length_i |-> abort)
        else $error("oversize abort missing");
    // set wins: a clear in the abort cycle is lost
    a_err_clear: assert property (@(posedge clk_i) disable iff (rst_i)
        bit_clr(`EEFL_B_TXERR) && !abort |=> !tx_err_q) else $error("error not cleared");
    a_no_retry: assert property (@(posedge clk_i) disable iff (rst_i)
        abort |=> st_q == eefl_pkg::TX_IDLE) else $error("abort retried");
    a_vector_once: assert property (@(posedge clk_i) disable iff (rst_i)
        tx_vector_write_o |=> !tx_vector_write_o) else $error("vector written twice");

    //------------------------------------------------
    // checks on flags
    //------------------------------------------------
    a_req_fall_done: assert property (@(posedge clk_i) disable iff (rst_i)
        req_fall |=> tx_done_q) else $error("done flag not set");
    a_done_sticky: assert property (@(posedge clk_i) disable iff (rst_i)
        tx_done_q && !bit_clr(`EEFL_B_TXDONE) |=> tx_done_q) else $error("done flag lost");
    a_done_cause: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(tx_done_q) |-> $past(tx_request_q)) else $error("done without request");
    a_link_mirror: assert property (@(posedge clk_i) disable iff (rst_i)
        phy_en_q == 2'b11 |-> link_flag == plnk_q) else $error("link flag not mirrored");
    a_copy_fall_set: assert property (@(posedge clk_i) disable iff (rst_i)
        copy_fall |=> copy_done_q) else $error("copy done not set");
    a_copy_sticky: assert property (@(posedge clk_i) disable iff (rst_i)
        copy_done_q && !bit_clr(`EEFL_B_COPY) |=> copy_done_q) else $error("copy done lost");
    a_pend_hold: assert property (@(posedge clk_i) disable iff (rst_i)
        rx_pend && !pkt_dec |=> rx_pend) else $error("pending lost");
    a_pend_clear: assert property (@(posedge clk_i) disable iff (rst_i)
        pkt_dec && !rx_new && pkt_cnt_q == 8'h01 |=> !rx_pend) else $error("pending stuck");
    a_wake_count: assert property (@(posedge clk_i) disable iff (rst_i)
        rx_new && !pkt_dec && pkt_cnt_q == 8'h00 |=> pkt_cnt_q == 8'h01)
        else $error("counter not raised");
    a_wake_refused: assert property (@(posedge clk_i) disable iff (rst_i)
        rx_packet_stored_i && (power_save_i || !rx_enable_i) && !pkt_dec |=> $stable(pkt_cnt_q))
        else $error("counted while disabled");

    //------------------------------------------------
    // checks on the request output
    //------------------------------------------------
    a_link_request: assert property (@(posedge clk_i) disable iff (rst_i)
        link_flag && enable_q[`EEFL_B_LINK] && enable_q[`EEFL_B_GLOBAL] |=> !request_n_o)
        else $error("link request missing");
    a_copy_request: assert property (@(posedge clk_i) disable iff (rst_i)
        copy_done_q && enable_q[`EEFL_B_COPY] && enable_q[`EEFL_B_GLOBAL] |=> !request_n_o)
        else $error("copy request missing");
    a_pend_request: assert property (@(posedge clk_i) disable iff (rst_i)
        rx_pend && enable_q[`EEFL_B_RXPEND] && enable_q[`EEFL_B_GLOBAL] |=> !request_n_o)
        else $error("pending request missing");
    a_idle_release: assert property (@(posedge clk_i) disable iff (rst_i)
        !tx_err_q && !tx_done_q && !link_flag && !copy_done_q && !rx_pend |=> request_n_o)
        else $error("request without flag");
endmodule : eefl_top
`default_nettype wire

// >>> test/eefl_host.sv
// host model: drives the register port and returns the read data
`timescale 1ns/1ns
`default_nettype none
module eefl_host (
    // clock
    input  wire logic       clk_i,
    // register port
    output logic      [2:0] addr_o,
    output logic      [7:0] wdata_o,
    output logic            wr_o,
    output logic            clr_o,
    output logic            rd_o,
    input  wire logic [7:0] rdata_i
);
    initial {addr_o, wdata_o, wr_o, clr_o, rd_o} = 14'h0000;
    // kind 1 write, 2 bit clear, 3 read; data taken the cycle after a read
    task access(input logic [1:0] kind, input logic [2:0] a, input logic [7:0] d,
                output logic [7:0] q);
        @(posedge clk_i);
        addr_o  <= a;
        wdata_o <= d;
        wr_o    <= (kind == 2'h1);
        clr_o   <= (kind == 2'h2);
        rd_o    <= (kind == 2'h3);
        @(posedge clk_i);
        {wr_o, clr_o, rd_o} <= 3'h0;
        #1 q = rdata_i;
    endtask : access
endmodule : eefl_host
`default_nettype wire

// >>> test/testbench.sv
// self-checking bench of the event flag logic
`timescale 1ns/1ns
`default_nettype none
`include "eefl_cfg.svh"
module testbench;
    logic        clk_i, rst_i, wr_s, clr_s, rd_s, busy, pp, psave, rx_en, vec_wr, req_n;
    logic [2:0]  addr;
    logic [7:0]  wdata, rdata, q, en;
    logic [5:0]  ev;
    logic [3:0]  rmax;
    logic [15:0] win, maxlen;
    logic [31:0] seed;
    int          num_errors, tests_run, cycles, vec_count, n;

    eefl_host host_u (
        .clk_i(clk_i), .addr_o(addr), .wdata_o(wdata), .wr_o(wr_s), .clr_o(clr_s),
        .rd_o(rd_s), .rdata_i(rdata)
    );
    eefl_top #(.WAIT_FOREVER_CFG_CYC(20)) dut_u (
        .clk_i(clk_i), .rst_i(rst_i), .addr_i(addr), .wdata_i(wdata), .wr_i(wr_s),
        .clr_i(clr_s), .rd_i(rd_s), .rdata_o(rdata), .medium_busy_i(busy),
        .tx_byte_i(ev[0]), .collision_i(ev[1]), .tx_end_i(ev[2]),
        .retry_maximum_i(rmax), .collision_window_i(win), .max_frame_length_i(maxlen),
        .per_packet_cfg_select_i(pp), .per_packet_huge_allow_i(pp),
        .phy_link_event_i(ev[3]), .copy_engine_finish_i(ev[4]),
        .rx_packet_stored_i(ev[5]), .power_save_i(psave), .rx_enable_i(rx_en),
        .tx_vector_write_o(vec_wr), .request_n_o(req_n)
    );

    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end

    always @(posedge clk_i) begin
        cycles++;
        if (vec_wr === 1'b1) vec_count++;
        if (cycles == 20000) begin
            num_errors++;
            report_and_stop();
        end
    end

    function logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd

    task check(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task wr(input logic [2:0] a, input logic [7:0] d);
        host_u.access(2'h1, a, d, q);
    endtask : wr

    task cl(input logic [2:0] a, input logic [7:0] d);
        host_u.access(2'h2, a, d, q);
    endtask : cl

    task rc(input logic [2:0] a, input logic [7:0] m, input logic [7:0] e);
        host_u.access(2'h3, a, 8'h00, q);
        check(q & m, e);
    endtask : rc

    task rq(input logic e);
        repeat (2) @(posedge clk_i);
        #1 check({7'h00, req_n}, {7'h00, e});
    endtask : rq

    // event bit b held high for c cycles
    task pulse(input int b, input int c);
        @(posedge clk_i);
        ev[b] <= 1'b1;
        repeat (c) @(posedge clk_i);
        ev[b] <= 1'b0;
    endtask : pulse

    task tx_case(input logic [7:0] cfg, input logic p, input int nb, input logic c,
                 input logic [3:0] rm, input logic [15:0] w, input logic [15:0] ml,
                 input logic err, input logic late);
        int v;
        v = vec_count;
        cl(`EEFL_A_FLAGS, 8'hFF);
        cl(`EEFL_A_STATUS, 8'hFF);
        wr(`EEFL_A_CFG, cfg);
        rmax <= rm;
        win <= w;
        maxlen <= ml;
        pp <= p;
        wr(`EEFL_A_CTRL, 8'h08);
        repeat (2) @(posedge clk_i);
        pulse(0, nb);
        if (c) pulse(1, 1);
        if (!err) pulse(2, 1);
        repeat (3) @(posedge clk_i);
        rc(`EEFL_A_FLAGS, 8'h0A, {6'h02, err, 1'b0});
        rc(`EEFL_A_STATUS, 8'h12, {3'h0, late, 2'h0, err, 1'b0});
        rc(`EEFL_A_CTRL, 8'h08, 8'h00);
        check(8'(vec_count - v), 8'h01);
    endtask : tx_case

    task wait_forever_cfg(input logic wf);
        cl(`EEFL_A_FLAGS, 8'hFF);
        wr(`EEFL_A_CFG, {6'h00, wf, 1'b0});
        busy <= 1'b1;
        wr(`EEFL_A_CTRL, 8'h08);
        repeat (30) @(posedge clk_i);
        busy <= 1'b0;
        rc(`EEFL_A_FLAGS, 8'h0A, wf ? 8'h00 : 8'h0A);
        rc(`EEFL_A_CTRL, 8'h08, wf ? 8'h08 : 8'h00);
        if (wf) wr(`EEFL_A_CTRL, 8'h00);
        if (wf) rc(`EEFL_A_FLAGS, 8'h0A, 8'h08);
    endtask : wait_forever_cfg

    task report_and_stop();
        $display("mismatches %0d, comparisons %0d", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : report_and_stop

    //--------------------------------------------------------------
    // scenarios
    //--------------------------------------------------------------
    initial begin
        {rst_i, busy, pp, psave, rx_en, ev, rmax} = {5'h11, 6'h00, 4'hF};
        {win, maxlen, seed, num_errors, tests_run, cycles, vec_count} = '0;
        seed = 32'd87;
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        rq(1'b1);
        rc(`EEFL_A_FLAGS, 8'hFF, 8'h00);
        tx_case(8'h01, 0, 5, 0, 15, 16'hFFFF, 16'h0004, 1, 0);
        tx_case(8'h01, 1, 5, 0, 15, 16'hFFFF, 16'h0004, 0, 0);
        tx_case(8'h05, 0, 5, 0, 15, 16'hFFFF, 16'h0004, 0, 0);
        tx_case(8'h01, 0, 3, 1, 0, 16'h0064, 16'h0400, 0, 0);
        tx_case(8'h00, 0, 3, 1, 0, 16'h0064, 16'h0400, 1, 0);
        tx_case(8'h00, 0, 12, 1, 15, 16'h000A, 16'h0400, 1, 0);
        tx_case(8'h00, 0, 65, 1, 15, 16'hFFFF, 16'h0400, 1, 1);
        tx_case(8'h00, 0, 3, 1, 15, 16'h0064, 16'h0400, 0, 0);
        wait_forever_cfg(1'b1);
        wait_forever_cfg(1'b0);
        wr(`EEFL_A_CTRL, 8'h20);
        pulse(4, 1);
        rc(`EEFL_A_FLAGS, 8'h20, 8'h20);
        cl(`EEFL_A_FLAGS, 8'h20);
        rc(`EEFL_A_FLAGS, 8'h20, 8'h00);
        wr(`EEFL_A_CTRL, 8'h20);
        wr(`EEFL_A_CTRL, 8'h00);
        rc(`EEFL_A_FLAGS, 8'h20, 8'h20);
        pulse(3, 1);
        rc(`EEFL_A_FLAGS, 8'h10, 8'h00);
        wr(`EEFL_A_PHYEN, 8'h12);
        pulse(3, 1);
        rc(`EEFL_A_FLAGS, 8'h10, 8'h10);
        wr(`EEFL_A_ENABLES, 8'h90);
        rq(1'b0);
        wr(`EEFL_A_PHYEN, 8'h02);
        rq(1'b1);
        wr(`EEFL_A_PHYEN, 8'h12);
        cl(`EEFL_A_FLAGS, 8'h10);
        rc(`EEFL_A_FLAGS, 8'h10, 8'h10);
        rc(`EEFL_A_PHYFLAG, 8'h14, 8'h14);
        rc(`EEFL_A_FLAGS, 8'h10, 8'h00);
        n = int'(rnd() % 32'd8) + 1;
        wr(`EEFL_A_ENABLES, 8'hC0);
        repeat (n) pulse(5, 1);
        rc(`EEFL_A_PKTCNT, 8'hFF, 8'(n));
        rq(1'b0);
        cl(`EEFL_A_FLAGS, 8'h40);
        rc(`EEFL_A_FLAGS, 8'h40, 8'h40);
        repeat (n - 1) cl(`EEFL_A_PKTCNT, 8'h01);
        rc(`EEFL_A_FLAGS, 8'h40, 8'h40);
        cl(`EEFL_A_PKTCNT, 8'h01);
        rc(`EEFL_A_FLAGS, 8'h40, 8'h00);
        rq(1'b1);
        pulse(5, 1);
        rq(1'b0);
        rc(`EEFL_A_PKTCNT, 8'hFF, 8'h01);
        rc(`EEFL_A_STATUS, 8'h80, 8'h80);
        psave <= 1'b1;
        pulse(5, 1);
        psave <= 1'b0;
        rc(`EEFL_A_PKTCNT, 8'hFF, 8'h01);
        repeat (8) begin
            en = 8'(rnd());
            wr(`EEFL_A_ENABLES, en);
            rc(`EEFL_A_ENABLES, 8'hFF, en & 8'hFA);
            rc(`EEFL_A_FLAGS, 8'hFF, 8'h6A);
            rq(!(en[7] && (en & 8'h6A) != 8'h00));
        end
        wr(`EEFL_A_ENABLES, 8'h82);
        rq(1'b0);
        cl(`EEFL_A_FLAGS, 8'h02);
        rq(1'b1);
        report_and_stop();
    end
endmodule : testbench
`default_nettype wire
